// [design/mwl_pkg.sv]
// Package for the mode-word load and initialization tracker.
package mwl_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_TIMING = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MRW_MIN = 8'h0c;

    // Mode word field positions.
    localparam int CFG_LSB = 0;
    localparam int BLEN_LSB = 3;
    localparam int AMUX_BIT = 5;
    localparam int DLL_BIT = 7;
    localparam int DRV_BIT = 8;
    localparam int TERM_BIT = 9;
    localparam int ZERO_LSB = 10;
    localparam int MUX_ZERO_MSB = 18;

    // Values after reset.
    localparam logic [9:0] MODE_RESET = 10'h000;
    localparam logic [1:0] DUMMY_MIN = 2'h2;
    localparam logic [15:0] TIMING_RESET = 16'h4452;

    // Initialization counts.
    localparam int IDLE_INIT_COUNT = 1024;
    localparam int BANK_COUNT = 8;
    localparam int DLL_LOCK_CYCLES = 1024;

    // Clock and stabilization time.
    localparam int CLK_PERIOD_NS = 50;
    localparam int STABLE_TIME_US = 200;
    localparam int STABLE_CYCLES = (STABLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Command encodings seen on the command pins.
    typedef enum logic [2:0] {
        CMD_IDLE = 3'b000,
        CMD_MODE_LOAD = 3'b001,
        CMD_REFRESH = 3'b010,
        CMD_READ = 3'b011,
        CMD_WRITE = 3'b100
    } mwl_cmd_t;

    // One command as registered on the command clock.
    typedef struct packed {
        mwl_cmd_t cmd;
        logic [2:0] bank;
        logic [18:0] addr;
    } mwl_cmd_word_t;

    // Decoded timing for the current configuration.
    typedef struct packed {
        logic [3:0] row_cycle;
        logic [3:0] read_lat;
        logic [3:0] write_lat;
        logic [3:0] burst_words;
    } mwl_timing_t;

endpackage

// [design/mwl_mode_register.sv]
// Mode-word capture, latency decode and initialization progress tracking.
`timescale 1ns/10ps

module mwl_mode_register #(
    parameter int STABLE_CYC = mwl_pkg::STABLE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire mwl_pkg::mwl_cmd_word_t cmd_in,
    input wire logic cmd_valid,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic mux_mode_reg,
    output logic dll_on_reg,
    output logic drive_match_reg,
    output logic termination_reg,
    output mwl_pkg::mwl_timing_t timing_reg,
    output logic init_done_reg,
    output logic seq_error_reg
);

    ////////////////////////////////////////////////////////////////////////
    // Mode word capture.

    logic [9:0] mode_reg;
    logic [2:0] run_len_reg;
    logic [12:0] idle_cnt_reg;
    logic [7:0] bank_done_reg;
    logic [17:0] stable_cnt_reg;
    logic [10:0] dll_cnt_reg;
    logic loaded_reg;
    logic prev_load_reg;
    logic [1:0] dummy_min_reg;
    logic err_reg;
    logic [18:0] zero_mask;
    logic is_load;
    logic is_idle;
    logic is_ref;
    logic valid_word;
    logic stable_ok;

    assign is_load = cmd_valid && cmd_in.cmd == mwl_pkg::CMD_MODE_LOAD;
    assign is_idle = !cmd_valid || cmd_in.cmd == mwl_pkg::CMD_IDLE;
    assign is_ref = cmd_valid && cmd_in.cmd == mwl_pkg::CMD_REFRESH;
    assign stable_ok = stable_cnt_reg >= 18'(STABLE_CYC);

    // Reserved high address bits must be zero; bit 18 counts in multiplexed mode.
    always_comb begin
        zero_mask = 19'h3fc00;
        if (mux_mode_reg) begin
            zero_mask = 19'h7fc00;
        end
    end

    // A load with nonzero reserved bits is not taken as a mode word.
    assign valid_word = (cmd_in.addr & zero_mask) == 19'h00000;

    // The word loaded last in a run of back-to-back loads is the valid one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= mwl_pkg::MODE_RESET;
        end else if (is_load && valid_word) begin
            mode_reg <= cmd_in.addr[9:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mux_mode_reg <= 1'b0;
            dll_on_reg <= 1'b0;
            drive_match_reg <= 1'b0;
            termination_reg <= 1'b0;
        end else begin
            mux_mode_reg <= mode_reg[mwl_pkg::AMUX_BIT];
            dll_on_reg <= mode_reg[mwl_pkg::DLL_BIT];
            drive_match_reg <= mode_reg[mwl_pkg::DRV_BIT];
            termination_reg <= mode_reg[mwl_pkg::TERM_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latency decode.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timing_reg <= mwl_pkg::TIMING_RESET;
        end else begin
            case (mode_reg[2:0])
                3'b000, 3'b001: timing_reg[15:4] <= {4'h4, 4'h4, 4'h5};
                3'b010: timing_reg[15:4] <= {4'h6, 4'h6, 4'h7};
                3'b011: timing_reg[15:4] <= {4'h8, 4'h8, 4'h9};
                3'b100: timing_reg[15:4] <= {4'h3, 4'h3, 4'h4};
                3'b101: timing_reg[15:4] <= {4'h5, 4'h5, 4'h6};
                default: timing_reg[15:4] <= 12'h000;
            endcase
            if (mode_reg[mwl_pkg::AMUX_BIT] && mode_reg[2:1] != 2'b11) begin
                timing_reg.read_lat <= mwl_lat(mode_reg[2:0]) + 4'h1;
                timing_reg.write_lat <= mwl_lat(mode_reg[2:0]) + 4'h2;
            end
            case (mode_reg[4:3])
                2'b00: timing_reg.burst_words <= 4'h2;
                2'b01: timing_reg.burst_words <= 4'h4;
                2'b10: timing_reg.burst_words <= 4'h8;
                default: timing_reg.burst_words <= 4'h0;
            endcase
        end
    end

    function automatic logic [3:0] mwl_lat(input logic [2:0] code);
        case (code)
            3'b010: mwl_lat = 4'h6;
            3'b011: mwl_lat = 4'h8;
            3'b100: mwl_lat = 4'h3;
            3'b101: mwl_lat = 4'h5;
            default: mwl_lat = 4'h4;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Initialization progress.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stable_cnt_reg <= 18'h00000;
        end else if (!stable_ok && is_idle) begin
            stable_cnt_reg <= stable_cnt_reg + 18'h00001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_len_reg <= 3'h0;
            prev_load_reg <= 1'b0;
            loaded_reg <= 1'b0;
        end else begin
            prev_load_reg <= is_load;
            if (is_load) begin
                run_len_reg <= (prev_load_reg && run_len_reg != 3'h7) ?
                    run_len_reg + 3'h1 : 3'h1;
            end
            if (prev_load_reg && !is_load && run_len_reg > {1'b0, dummy_min_reg}) begin
                loaded_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_cnt_reg <= 13'h0000;
            bank_done_reg <= 8'h00;
        end else if (is_load) begin
            idle_cnt_reg <= 13'h0000;
            bank_done_reg <= 8'h00;
        end else if (loaded_reg && !init_done_reg) begin
            if (is_idle && idle_cnt_reg < 13'(mwl_pkg::IDLE_INIT_COUNT)) begin
                idle_cnt_reg <= idle_cnt_reg + 13'h0001;
            end
            if (is_ref) begin
                bank_done_reg[cmd_in.bank] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_done_reg <= 1'b0;
        end else if (loaded_reg && &bank_done_reg &&
                     idle_cnt_reg == 13'(mwl_pkg::IDLE_INIT_COUNT)) begin
            init_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dll_cnt_reg <= 11'h000;
        end else if (!dll_on_reg) begin
            dll_cnt_reg <= 11'h000;
        end else if (dll_cnt_reg < 11'(mwl_pkg::DLL_LOCK_CYCLES)) begin
            dll_cnt_reg <= dll_cnt_reg + 11'h001;
        end
    end

    // Flags a mode load before the stable period or a read while the DLL is on but not yet locked.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_reg <= 1'b0;
        end else if ((is_load && !stable_ok) ||
                     (cmd_valid && cmd_in.cmd == mwl_pkg::CMD_READ && dll_on_reg &&
                      dll_cnt_reg < 11'(mwl_pkg::DLL_LOCK_CYCLES))) begin
            err_reg <= 1'b1;
        end
    end

    assign seq_error_reg = err_reg;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dummy_min_reg <= mwl_pkg::DUMMY_MIN;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
                !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                if (s_axi_awaddr[7:0] == mwl_pkg::OFF_MRW_MIN) begin
                    if (s_axi_wstrb[0] && s_axi_wdata[1:0] >= 2'h2) begin
                        dummy_min_reg <= s_axi_wdata[1:0];
                    end
                end else if (s_axi_awaddr[7:0] != mwl_pkg::OFF_MODE &&
                             s_axi_awaddr[7:0] != mwl_pkg::OFF_TIMING &&
                             s_axi_awaddr[7:0] != mwl_pkg::OFF_STATUS) begin
                    s_axi_bresp <= 2'b10;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr[7:0])
                    mwl_pkg::OFF_MODE: s_axi_rdata <= {22'h000000, mode_reg};
                    mwl_pkg::OFF_TIMING: s_axi_rdata <= {16'h0000, timing_reg};
                    mwl_pkg::OFF_STATUS: s_axi_rdata <= {init_done_reg, err_reg,
                        loaded_reg, stable_ok, bank_done_reg, 7'h00, idle_cnt_reg};
                    mwl_pkg::OFF_MRW_MIN: s_axi_rdata <= {30'h00000000, dummy_min_reg};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    a_done_needs_banks: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(init_done_reg) |-> $past(&bank_done_reg))
        else $error("init done without all banks refreshed");

    a_zero_bits_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (is_load && cmd_in.addr[17:10] != 8'h00) |=> $stable(mode_reg))
        else $error("mode word taken with reserved bits set");

    a_mode_capture: assert property (@(posedge aclk) disable iff (!aresetn)
        (is_load && valid_word) |=> mode_reg == $past(cmd_in.addr[9:0]))
        else $error("mode word not captured");

    a_mux_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        (is_load && valid_word) |=> ##1 mux_mode_reg == $past(cmd_in.addr[5], 2))
        else $error("addressing mode not updated");

    a_cfg_decode: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode_reg[2:0] == 3'b100 && !mode_reg[5]) [*2] |-> timing_reg.read_lat == 4'h3)
        else $error("latency decode wrong");

    a_mux_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode_reg[2:0] == 3'b010 && mode_reg[5]) [*2] |-> timing_reg.write_lat == 4'h8)
        else $error("multiplexed latency not extended");

    a_burst_len: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode_reg[4:3] == 2'b01) [*2] |-> timing_reg.burst_words == 4'h4)
        else $error("burst length decode wrong");

    a_dll_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        ($rose(mode_reg[7])) |=> dll_on_reg)
        else $error("DLL enable not applied");

endmodule

// [bench/mwl_ctl_model.sv]
// Controller-side model that drives the command pins of the mode-word tracker.
`timescale 1ns/10ps
module mwl_ctl_model #(
    parameter int SETTLE = 4
) (
    input wire logic aclk,
    output mwl_pkg::mwl_cmd_word_t cmd_in,
    output logic cmd_valid
);
    initial begin
        cmd_in = '0;
        cmd_valid = 1'b0;
    end
    // Idle address lines toggle so a stale value is never mistaken for a held one.
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            cmd_valid <= 1'b0;
            cmd_in <= {mwl_pkg::CMD_IDLE, 3'h0, ~cmd_in.addr};
        end
    endtask
    // One command to a bank, then back to idle.
    task automatic one(input mwl_pkg::mwl_cmd_t c, input logic [2:0] b, input logic [18:0] a);
        @(posedge aclk);
        cmd_valid <= 1'b1;
        cmd_in <= {c, b, a};
        idle(1);
    endtask
    // Dummy loads carry a zero address and the last load carries the word.
    task automatic load_run(input int n, input logic [18:0] w);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            cmd_valid <= 1'b1;
            cmd_in <= {mwl_pkg::CMD_MODE_LOAD, 3'h0, (i == n - 1) ? w : 19'h0};
        end
        idle(SETTLE);
    endtask
endmodule

// [bench/test_memory_init_mode_register.sv]
// Self-checking bench for the mode-word tracker with an AXI4-Lite master.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_memory_init_mode_register;
    logic aclk = 1'b0;
    logic aresetn;
    logic [31:0] awaddr, wdata, araddr;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, cmd_valid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic mux_mode, dll_on, drive_match, term, init_done, seq_err;
    mwl_pkg::mwl_timing_t timing;
    mwl_pkg::mwl_cmd_word_t cmd_in;
    int checks = 0, miscompares = 0;
    logic [31:0] lfsr = 32'h5f87;
    always #25 aclk = ~aclk;
    mwl_ctl_model ctl (.aclk(aclk), .cmd_in(cmd_in), .cmd_valid(cmd_valid));
    mwl_mode_register #(.STABLE_CYC(10)) dut (
        .aclk(aclk), .aresetn(aresetn), .cmd_in(cmd_in), .cmd_valid(cmd_valid),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .mux_mode_reg(mux_mode), .dll_on_reg(dll_on), .drive_match_reg(drive_match),
        .termination_reg(term), .timing_reg(timing), .init_done_reg(init_done),
        .seq_error_reg(seq_err)
    );
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // Reserved codes give zero latency; multiplexed addressing adds a cycle.
    function automatic logic [15:0] exp_timing(input logic [9:0] m);
        int bw [4] = '{2, 4, 8, 0};
        int rcs [8] = '{4, 4, 6, 8, 3, 5, 0, 0};
        int rc;
        int rl;
        int wl;
        rc = rcs[m[2:0]];
        rl = (rc == 0) ? 0 : rc + m[5];
        wl = (rc == 0) ? 0 : rl + 1;
        return {rc[3:0], rl[3:0], wl[3:0], bw[m[4:3]][3:0]};
    endfunction
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        rs = bresp;
        `CHK(n < 50, 1'b1)
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
        `CHK(n < 50, 1'b1)
    endtask
    task automatic load_chk(input int n, input logic [18:0] w, input logic [9:0] m);
        ctl.load_run(n, w);
        `CHK(timing, exp_timing(m))
        `CHK({mux_mode, dll_on, drive_match, term}, {m[5], m[7], m[8], m[9]})
        axi_rd(8'h00);
        `CHK(rd, {22'h0, m})
    endtask
    task automatic test_done();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        test_done();
    end
    ////////////////////////////////////////
    initial begin
        logic [18:0] w;
        logic [31:0] r;
        logic [2:0] b;
        aresetn <= 1'b0;
        awaddr <= 32'h00000000;
        wdata <= 32'h00000000;
        araddr <= 32'h00000000;
        wstrb <= 4'hf;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK(timing, 16'h4452)
        axi_rd(8'h10);
        `CHK({rs, rd}, {2'b10, 32'h0})
        axi_wr(8'h20, 32'h1);
        `CHK(rs, 2'b10)
        axi_wr(8'h0c, 32'h3);
        axi_wr(8'h0c, 32'h1);
        wstrb <= 4'he;
        axi_wr(8'h0c, 32'h2);
        wstrb <= 4'hf;
        axi_rd(8'h0c);
        `CHK(rd, 32'h3)
        ctl.idle(12);
        load_chk(3, 19'h00123, 10'h123);
        axi_wr(8'h0c, 32'h2);
        load_chk(2, 19'h00123, 10'h123);
        axi_rd(8'h08);
        `CHK(rd[29], 1'b0)
        load_chk(3, 19'h01123, 10'h0);
        for (int c = 0; c < 14; c++) begin
            r = rnd();
            w = {9'h0, r[9:6], c[3], c[1:0], c[2:0]};
            load_chk(3, w, w[9:0]);
        end
        load_chk(1, 19'h40021, w[9:0]);
        load_chk(3, 19'h000a0, 10'h0a0);
        r = rnd();
        for (int k = 0; k < 8; k++) begin
            b = k[2:0] * 3'd5 + r[2:0];
            ctl.one(mwl_pkg::CMD_REFRESH, b, 19'h0);
            ctl.idle(2);
        end
        ctl.idle(970);
        `CHK(init_done, 1'b0)
        ctl.idle(160);
        `CHK(init_done, 1'b1)
        axi_rd(8'h08);
        `CHK(rd[31:20], 12'hbff)
        `CHK(rd[12:0], 13'h0400)
        ctl.one(mwl_pkg::CMD_READ, 3'h1, 19'h0);
        ctl.idle(2);
        `CHK(seq_err, 1'b0)
        ctl.load_run(3, 19'h00020);
        ctl.load_run(3, 19'h000a0);
        ctl.one(mwl_pkg::CMD_READ, 3'h2, 19'h0);
        ctl.idle(2);
        `CHK(seq_err, 1'b1)
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK({seq_err, init_done, mux_mode, timing}, {3'b000, 16'h4452})
        ctl.load_run(3, 19'h00001);
        `CHK(seq_err, 1'b1)
        test_done();
    end
endmodule
